// ---- design/asfc_consts.vh ----
`ifndef ASFC_CONSTS_VH
`define ASFC_CONSTS_VH
// Register byte offsets
`define ASFC_OFF_CTRL    8'h00
`define ASFC_OFF_BAUD    8'h04
`define ASFC_OFF_TXDATA  8'h08
`define ASFC_OFF_RXDATA  8'h0c
`define ASFC_OFF_STATUS  8'h10
// Control bits
`define ASFC_CB_PORT     0
`define ASFC_CB_TXEN     1
`define ASFC_CB_RXEN     2
`define ASFC_CB_NINE     3
`define ASFC_CB_ADDR     4
`define ASFC_CB_BRG16    5
`define ASFC_CB_HISPD    6
`define ASFC_CB_SYNC     7
`define ASFC_CB_WAKE     8
`define ASFC_CB_ABD      9
`define ASFC_CB_BRK      10
`define ASFC_CTRL_W      11
`define ASFC_CTRL_RST    11'h000
`define ASFC_BAUD_RST    16'h0000
// Status bits
`define ASFC_SB_TXRDY    0
`define ASFC_SB_TEMPTY   1
`define ASFC_SB_RXAV     2
`define ASFC_SB_OVR      3
`define ASFC_SB_RXIDLE   4
`define ASFC_SB_ABDOVF   5
`define ASFC_SB_WAKEF    6
`define ASFC_SB_FERR     7
// Bit timing: oversample ticks, prescale, bit counts, measure limit
`define ASFC_OS_M1       4'hf
`define ASFC_OS_HALF_M1  4'h7
`define ASFC_PRE_M1      2'h3
`define ASFC_LAST8       4'h7
`define ASFC_LAST9       4'h8
`define ASFC_FRAME8      4'ha
`define ASFC_FRAME9      4'hb
`define ASFC_FRAMEBRK    4'he
`define ASFC_ABD_MAX     22'h3fffff
`endif

// ---- design/asfc_baud.v ----
`timescale 1ns/1ns
`default_nettype none
`include "asfc_consts.vh"
module asfc_baud (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [15:0] div,
  input  wire        brg16,
  input  wire        hispd,
  output wire        os_tick
);
  reg  [15:0] cnt_q;
  reg  [1:0]  pre_q;
  reg         tick_q;
  wire [15:0] limit;

  // Eight-bit mode ignores the upper divisor byte
  assign limit   = brg16 ? div : {8'h00, div[7:0]};
  assign os_tick = tick_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 16'h0000;
      pre_q  <= 2'h0;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= 16'h0000;
      pre_q  <= pre_q + 2'h1;
      tick_q <= hispd | (pre_q == `ASFC_PRE_M1);
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // asfc_baud
`default_nettype wire

// ---- design/asfc_tx.v ----
`timescale 1ns/1ns
`default_nettype none
`include "asfc_consts.vh"
module asfc_tx (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       os_tick,
  input  wire       en,
  input  wire       load,
  input  wire       nine,
  input  wire       brk,
  input  wire [8:0] data,
  output wire       txd,
  output wire       empty
);
  reg [13:0] sr_q;
  reg [3:0]  os_q;
  reg [3:0]  bit_q;
  reg [3:0]  len_q;
  reg        txd_q;
  reg        empty_q;

  assign txd   = txd_q;
  assign empty = empty_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q    <= 14'h3fff;
      os_q    <= 4'h0;
      bit_q   <= 4'h0;
      len_q   <= `ASFC_FRAME8;
      txd_q   <= 1'b1;
      empty_q <= 1'b1;
    end else if (!en) begin
      txd_q   <= 1'b1;
      empty_q <= 1'b1;
    end else if (load) begin
      // Start bit space, then data LSb first, then stop marks
      if (brk) begin
        sr_q  <= {1'b1, 13'h0000};
        len_q <= `ASFC_FRAMEBRK;
      end else if (nine) begin
        sr_q  <= {4'hf, data, 1'b0};
        len_q <= `ASFC_FRAME9;
      end else begin
        sr_q  <= {5'h1f, data[7:0], 1'b0};
        len_q <= `ASFC_FRAME8;
      end
      os_q    <= 4'h0;
      bit_q   <= 4'h0;
      txd_q   <= 1'b0;
      empty_q <= 1'b0;
    end else if (!empty_q && os_tick) begin
      if (os_q == `ASFC_OS_M1) begin
        os_q <= 4'h0;
        if (bit_q == len_q - 4'h1) begin
          txd_q   <= 1'b1;
          empty_q <= 1'b1;
        end else begin
          sr_q  <= {1'b1, sr_q[13:1]};
          txd_q <= sr_q[1];
          bit_q <= bit_q + 4'h1;
        end
      end else begin
        os_q <= os_q + 4'h1;
      end
    end
  end
endmodule // asfc_tx
`default_nettype wire

// ---- design/asfc_top.v ----
// Function
// - Idle line at mark, NRZ bit levels
// - Mark is one, space is zero
// - One start bit, eight or nine data
// - Start bit space, stop bits mark
// - At least one stop bit per frame
// - Every bit but the start bit lasts one bit period
// - Baud generator, 8 or 16 bit divisor
// - Data least significant bit first
// - Independent paths, shared format and baud
// - No hardware parity, ninth bit raw
// - Asynchronous full duplex; synchronous mode select
// - Eight or nine bits, address detect
// - Flag overrun when receive buffer full
// - Flag framing error on bad stop
// - Send thirteen bit break character
// - Wake on break, automatic baud measure
// - Disabled section releases its pin
// - Shifter empty flag tracks transmit shifter
`timescale 1ns/1ns
`default_nettype none
`include "asfc_consts.vh"
module asfc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        serial_in_pin,
  output wire        serial_out_pin,
  output wire        serial_out_oe,
  output wire        serial_in_en
);
  localparam [3:0] RX_IDLE  = 4'b0001;
  localparam [3:0] RX_START = 4'b0010;
  localparam [3:0] RX_DATA  = 4'b0100;
  localparam [3:0] RX_STOP  = 4'b1000;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [`ASFC_CTRL_W-1:0] ctrl_q;
  reg  [15:0] baud_q;
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [31:0] rdata_d;
  reg         mapped_d;
  reg         oe_q;
  reg         inen_q;
  reg         pend_v_q;
  reg  [8:0]  pend_q;
  reg         rxd_q;
  reg         rxd_p_q;
  reg  [3:0]  rx_st_q;
  reg  [3:0]  rx_os_q;
  reg  [3:0]  rx_bit_q;
  reg  [8:0]  rx_sh_q;
  reg  [9:0]  rxf_q [0:1];
  reg         rxf_wp_q;
  reg         rxf_rp_q;
  reg  [1:0]  rxf_cnt_q;
  reg         ovr_q;
  reg         abd_run_q;
  reg  [21:0] abd_cnt_q;
  reg         abdovf_q;
  reg         wakef_q;
  wire        os_tick;
  wire        tx_empty;
  wire        tx_line;
  wire        done_d;
  wire        wr_d;
  wire        rd_d;
  wire        port_on;
  wire        tx_on;
  wire        rx_on;
  wire        fall;
  wire        rise;
  wire        tx_load;
  wire        rx_done;
  wire [8:0]  rx_char;
  wire        rx_keep;
  wire        rx_push;
  wire        rx_pop;
  wire        abd_on;
  wire        abd_done;
  wire        abd_ovf;
  wire [15:0] abd_q16;
  wire [15:0] abd_div;
  wire        wake_end;

  ////////////////////////////////////////////////////////////////////
  // Mode decode
  // Synchronous select parks both async engines with pins released
  assign port_on = ctrl_q[`ASFC_CB_PORT] & ~ctrl_q[`ASFC_CB_SYNC];
  assign tx_on   = port_on & ctrl_q[`ASFC_CB_TXEN];
  // Receiver stays deaf while waking or measuring the baud rate
  assign rx_on   = port_on & ctrl_q[`ASFC_CB_RXEN]
                 & ~ctrl_q[`ASFC_CB_WAKE]
                 & ~ctrl_q[`ASFC_CB_ABD];
  assign abd_on  = port_on & ctrl_q[`ASFC_CB_RXEN]
                 & ctrl_q[`ASFC_CB_ABD];

  ////////////////////////////////////////////////////////////////////
  // APB slave, two-cycle access phase
  assign done_d  = psel & penable & pready_q;
  assign wr_d    = done_d & pwrite & ~pslverr_q;
  assign rd_d    = done_d & ~pwrite & ~pslverr_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always @* begin
    rdata_d  = 32'h0000_0000;
    mapped_d = 1'b1;
    if (paddr == `ASFC_OFF_CTRL) begin
      rdata_d[`ASFC_CTRL_W-1:0] = ctrl_q;
    end else if (paddr == `ASFC_OFF_BAUD) begin
      rdata_d[15:0] = baud_q;
    end else if (paddr == `ASFC_OFF_TXDATA) begin
      rdata_d[8:0] = pend_q;
    end else if (paddr == `ASFC_OFF_RXDATA) begin
      rdata_d[9:0] = rxf_q[rxf_rp_q];
    end else if (paddr == `ASFC_OFF_STATUS) begin
      rdata_d[`ASFC_SB_TXRDY]  = ~pend_v_q;
      rdata_d[`ASFC_SB_TEMPTY] = tx_empty;
      rdata_d[`ASFC_SB_RXAV]   = (rxf_cnt_q != 2'h0);
      rdata_d[`ASFC_SB_OVR]    = ovr_q;
      rdata_d[`ASFC_SB_RXIDLE] = (rx_st_q == RX_IDLE);
      rdata_d[`ASFC_SB_ABDOVF] = abdovf_q;
      rdata_d[`ASFC_SB_WAKEF]  = wakef_q;
      rdata_d[`ASFC_SB_FERR]   = rxf_q[rxf_rp_q][9];
    end else begin
      mapped_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped_d;
      if (psel & ~penable) begin
        prdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and divisor registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ASFC_CTRL_RST;
    end else begin
      if (tx_load) begin
        ctrl_q[`ASFC_CB_BRK] <= 1'b0;
      end
      if (abd_done | abd_ovf) begin
        ctrl_q[`ASFC_CB_ABD] <= 1'b0;
      end
      if (wake_end) begin
        ctrl_q[`ASFC_CB_WAKE] <= 1'b0;
      end
      if (wr_d && paddr == `ASFC_OFF_CTRL) begin
        ctrl_q <= pwdata[`ASFC_CTRL_W-1:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_q <= `ASFC_BAUD_RST;
    end else if (abd_done) begin
      baud_q <= abd_div;
    end else if (wr_d && paddr == `ASFC_OFF_BAUD) begin
      baud_q <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin ownership
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q   <= 1'b0;
      inen_q <= 1'b0;
    end else begin
      oe_q   <= tx_on;
      inen_q <= port_on & ctrl_q[`ASFC_CB_RXEN];
    end
  end

  assign serial_out_oe = oe_q;
  assign serial_in_en  = inen_q;

  ////////////////////////////////////////////////////////////////////
  // Shared oversample clock
  asfc_baud u_baud (
    .clk     (pclk),
    .rst_n   (presetn),
    .div     (baud_q),
    .brg16   (ctrl_q[`ASFC_CB_BRG16]),
    .hispd   (ctrl_q[`ASFC_CB_HISPD]),
    .os_tick (os_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Transmit side: one pending character ahead of the shifter
  // Writes while a character is pending are dropped
  assign tx_load = tx_on & pend_v_q & tx_empty;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_v_q <= 1'b0;
      pend_q   <= 9'h000;
    end else if (!tx_on) begin
      pend_v_q <= 1'b0;
    end else if (tx_load) begin
      pend_v_q <= 1'b0;
    end else if (wr_d && paddr == `ASFC_OFF_TXDATA && !pend_v_q) begin
      pend_v_q <= 1'b1;
      pend_q   <= pwdata[8:0];
    end
  end

  // First bit may start up to one tick early; baud clock is shared
  asfc_tx u_tx (
    .clk     (pclk),
    .rst_n   (presetn),
    .os_tick (os_tick),
    .en      (tx_on),
    .load    (tx_load),
    .nine    (ctrl_q[`ASFC_CB_NINE]),
    .brk     (ctrl_q[`ASFC_CB_BRK]),
    .data    (pend_q),
    .txd     (tx_line),
    .empty   (tx_empty)
  );

  assign serial_out_pin = tx_line;

  ////////////////////////////////////////////////////////////////////
  // Receive line sampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_q   <= 1'b1;
      rxd_p_q <= 1'b1;
    end else begin
      rxd_q   <= serial_in_pin;
      rxd_p_q <= rxd_q;
    end
  end

  assign fall = rxd_p_q & ~rxd_q;
  assign rise = ~rxd_p_q & rxd_q;

  ////////////////////////////////////////////////////////////////////
  // Receive state machine, sixteen ticks per bit
  assign rx_done = (rx_st_q == RX_STOP) & os_tick
                 & (rx_os_q == `ASFC_OS_M1);
  assign rx_char = ctrl_q[`ASFC_CB_NINE] ? rx_sh_q
                 : {1'b0, rx_sh_q[8:1]};
  // Nine-bit address mode drops characters whose ninth bit is clear
  assign rx_keep = ~(ctrl_q[`ASFC_CB_ADDR] & ctrl_q[`ASFC_CB_NINE]
                 & ~rx_sh_q[8]);
  assign rx_push = rx_done & rx_keep & (rxf_cnt_q != 2'h2);
  assign rx_pop  = rd_d & (paddr == `ASFC_OFF_RXDATA)
                 & (rxf_cnt_q != 2'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= RX_IDLE;
      rx_os_q  <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
    end else if (!rx_on) begin
      rx_st_q <= RX_IDLE;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (fall) begin
            rx_st_q <= RX_START;
            rx_os_q <= 4'h0;
          end
        end
        RX_START: begin
          if (os_tick) begin
            if (rx_os_q == `ASFC_OS_HALF_M1) begin
              rx_os_q  <= 4'h0;
              rx_bit_q <= 4'h0;
              // Glitch guard: start must still be space mid-bit
              rx_st_q  <= rxd_q ? RX_IDLE : RX_DATA;
            end else begin
              rx_os_q <= rx_os_q + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (os_tick) begin
            if (rx_os_q == `ASFC_OS_M1) begin
              rx_os_q  <= 4'h0;
              rx_sh_q  <= {rxd_q, rx_sh_q[8:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == (ctrl_q[`ASFC_CB_NINE] ?
                  `ASFC_LAST9 : `ASFC_LAST8)) begin
                rx_st_q <= RX_STOP;
              end
            end else begin
              rx_os_q <= rx_os_q + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (os_tick) begin
            if (rx_os_q == `ASFC_OS_M1) begin
              rx_os_q <= 4'h0;
              rx_st_q <= RX_IDLE;
            end else begin
              rx_os_q <= rx_os_q + 4'h1;
            end
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer, framing error kept per entry
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_rxf
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rxf_q[gi] <= 10'h000;
        end else if (rx_push && rxf_wp_q == gi) begin
          rxf_q[gi] <= {~rxd_q, rx_char};
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_wp_q  <= 1'b0;
      rxf_rp_q  <= 1'b0;
      rxf_cnt_q <= 2'h0;
    end else begin
      if (rx_push) begin
        rxf_wp_q <= ~rxf_wp_q;
      end
      if (rx_pop) begin
        rxf_rp_q <= ~rxf_rp_q;
      end
      if (rx_push & ~rx_pop) begin
        rxf_cnt_q <= rxf_cnt_q + 2'h1;
      end else if (rx_pop & ~rx_push) begin
        rxf_cnt_q <= rxf_cnt_q - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear, new event wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q    <= 1'b0;
      abdovf_q <= 1'b0;
      wakef_q  <= 1'b0;
    end else begin
      if (rx_done & rx_keep & (rxf_cnt_q == 2'h2)) begin
        ovr_q <= 1'b1;
      end else if (wr_d && paddr == `ASFC_OFF_STATUS &&
                   pwdata[`ASFC_SB_OVR]) begin
        ovr_q <= 1'b0;
      end
      if (abd_ovf) begin
        abdovf_q <= 1'b1;
      end else if (wr_d && paddr == `ASFC_OFF_STATUS &&
                   pwdata[`ASFC_SB_ABDOVF]) begin
        abdovf_q <= 1'b0;
      end
      if (ctrl_q[`ASFC_CB_WAKE] & port_on & fall) begin
        wakef_q <= 1'b1;
      end else if (wr_d && paddr == `ASFC_OFF_STATUS &&
                   pwdata[`ASFC_SB_WAKEF]) begin
        wakef_q <= 1'b0;
      end
    end
  end

  // Wake mode ends once the break has gone back to mark
  assign wake_end = ctrl_q[`ASFC_CB_WAKE] & wakef_q & rise;

  ////////////////////////////////////////////////////////////////////
  // Baud measure: low time of the start bit of a sync character
  assign abd_done = abd_on & abd_run_q & rise;
  assign abd_ovf  = abd_on & abd_run_q & (abd_cnt_q == `ASFC_ABD_MAX);
  assign abd_q16  = ctrl_q[`ASFC_CB_HISPD] ? abd_cnt_q[19:4]
                  : abd_cnt_q[21:6];
  assign abd_div  = (abd_q16 == 16'h0000) ? 16'h0000
                  : abd_q16 - 16'h0001;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abd_run_q <= 1'b0;
      abd_cnt_q <= 22'h000000;
    end else if (!abd_on || abd_done || abd_ovf) begin
      abd_run_q <= 1'b0;
    end else if (!abd_run_q && fall) begin
      abd_run_q <= 1'b1;
      abd_cnt_q <= 22'h000001;
    end else if (abd_run_q) begin
      abd_cnt_q <= abd_cnt_q + 22'h000001;
    end
  end

endmodule // asfc_top
`default_nettype wire

// ---- verification/asfc_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module asfc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        serial_in_en
);
  // Bench keeps 32 pclk per bit; start bit may lose one 2-cycle tick
  localparam int BIT = 32;
  logic [15:0] run_q;
  logic        last_q;
  //////////////////////////////////////////////////////////////////////////
  // Run length of the current line level, saturating on long idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= 16'h0001;
      last_q <= 1'b1;
    end else begin
      run_q  <= (serial_out_pin != last_q) ? 16'h0001 :
                run_q + {15'h0000, run_q != 16'hffff};
      last_q <= serial_out_pin;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_idle; !serial_out_oe |-> serial_out_pin; endproperty
  property p_low_run;
    (serial_out_oe && serial_out_pin && !last_q)
      |-> ((run_q + 16'h0002) % BIT <= 2);
  endproperty
  property p_stop_len;
    (serial_out_oe && !serial_out_pin && last_q) |-> run_q >= 16'h001e;
  endproperty
  property p_rel;
    $rose(presetn) |-> serial_out_pin && !serial_out_oe && !serial_in_en
                       && !pready;
  endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_wait;
    (psel && !penable) |=> !pready ##1 (pready && psel && penable);
  endproperty
  property p_map;
    pready |-> (pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
                                          8'h10}));
  endproperty
  property p_hold; (psel && penable && !pready) |=> $stable(prdata);
  endproperty
  property p_upper; (pready && !pwrite) |-> prdata[31:16] == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("line not at mark");
  a_low_run: assert property (p_low_run) else $error("low run");
  a_stop_len: assert property (p_stop_len) else $error("short high");
  a_rel: assert property (p_rel) else $error("reset outputs wrong");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
  a_wait: assert property (p_wait) else $error("wait state count");
  a_map: assert property (p_map) else $error("slave error decode");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_upper: assert property (p_upper) else $error("upper bits set");
  c_err: cover property (pready && pslverr);
  c_start: cover property (serial_out_oe && !serial_out_pin && last_q);
  c_rx: cover property (serial_in_en && $fell(serial_in_pin));
  c_rd: cover property (pready && !pwrite);
endmodule // asfc_chk
bind asfc_top asfc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .serial_in_en(serial_in_en));
`default_nettype wire

// ---- verification/asfc_remote.sv ----
`timescale 1ns/1ns
`default_nettype none
module asfc_remote #(
  parameter int BIT = 32
) (
  input  wire logic pclk,
  input  wire logic tx_line,
  input  wire logic tx_oe,
  output var  logic rx_line
);
  logic line;
  // Pull-up on a released line
  assign line = tx_oe ? tx_line : 1'b1;
  initial rx_line = 1'b1;
  task automatic bitout(input logic v);
    rx_line <= v;
    repeat (BIT) @(posedge pclk);
  endtask
  // Stop level is a bench choice so a framing fault can be forced
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    @(posedge pclk);
    bitout(1'b0);
    for (int i = 0; i < nb; i++) bitout(d[i]);
    bitout(stp);
    rx_line <= 1'b1;
  endtask
  task automatic recv(input int nb, output logic [8:0] d, output logic stp,
                      output logic ok);
    int n;
    n = 0;
    d = 9'h000;
    while (line !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    ok = (n < 20000);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge pclk);
      d[i] = line;
    end
    repeat (BIT) @(posedge pclk);
    stp = line;
  endtask
endmodule // asfc_remote
`default_nettype wire

// ---- verification/tb_async_serial_framing_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_async_serial_framing_core;
  localparam int BIT = 32;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic        serial_in_en;
  logic [31:0] rd;
  logic [31:0] v;
  logic        er;
  logic [8:0]  rxq[$];
  int          n_errors;
  int          checks_done;
  logic [10:0] cfg[5] = '{11'h041, 11'h043, 11'h045, 11'h047, 11'h0c7};
  asfc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .serial_in_en(serial_in_en));
  asfc_remote #(.BIT(BIT)) u_rem (.pclk(pclk), .tx_line(serial_out_pin),
    .tx_oe(serial_out_oe), .rx_line(serial_in_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("werr", 32'h0, {31'h0, er});
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Two chars out back to back while one char comes in
  task automatic tx_pair(input int nb, input logic brk);
    logic [8:0] c[2];
    logic [8:0] m;
    logic [8:0] r;
    logic [8:0] d;
    logic       s;
    logic       ok;
    m = (nb == 9) ? 9'h1ff : 9'h0ff;
    for (int i = 0; i < 2; i++) c[i] = 9'($urandom) & m;
    r = 9'($urandom) & m;
    fork
      begin
        apb(1'b1, 8'h08, {23'h0, c[0]});
        repeat (2) @(posedge pclk);
        rdchk("shf_busy", 8'h10, 32'h2, 32'h0);
        apb(1'b1, 8'h08, {23'h0, c[1]});
        repeat (2) @(posedge pclk);
        rdchk("txrdy", 8'h10, 32'h1, 32'h0);
      end
      u_rem.send(r, nb, 1'b1);
      for (int i = 0; i < 2; i++) begin
        u_rem.recv((brk && i == 0) ? 12 : nb, d, s, ok);
        chk("frame", 32'h1, {31'h0, ok});
        chk("txd", {23'h0, (brk && i == 0) ? 9'h000 : c[i]},
            {23'h0, d});
        chk("stop", 32'h1, {31'h0, s});
      end
    join
    repeat (BIT) @(posedge pclk);
    rdchk("rxd_dup", 8'h0c, 32'h3ff, {23'h0, r});
    rdchk("shf_idle", 8'h10, 32'h3, 32'h3);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    n_errors = 0;
    checks_done = 0;
    void'($urandom(31279));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl0", 8'h00, 32'hffffffff, 32'h0);
    rdchk("baud0", 8'h04, 32'hffffffff, 32'h0);
    rdchk("stat0", 8'h10, 32'h0f, 32'h03);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    v = $urandom;
    wr(8'h04, v);
    rdchk("baud", 8'h04, 32'hffffffff, {16'h0, v[15:0]});
    foreach (cfg[k]) begin
      wr(8'h00, {21'h0, cfg[k]});
      repeat (3) @(posedge pclk);
      chk("oe", {31'h0, cfg[k][1] & ~cfg[k][7]},
          {31'h0, serial_out_oe});
      chk("ien", {31'h0, cfg[k][2] & ~cfg[k][7]},
          {31'h0, serial_in_en});
    end
    // Upper divisor byte must be ignored in 8-bit mode
    // Leave synchronous select so both async paths run again
    wr(8'h00, 32'h47);
    wr(8'h04, 32'h5a01);
    tx_pair(8, 1'b0);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h6f);
    tx_pair(9, 1'b0);
    wr(8'h00, 32'h447);
    tx_pair(8, 1'b1);
    rdchk("brk_clr", 8'h00, 32'h400, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rxq.push_back(9'($urandom) & 9'h0ff);
      u_rem.send(rxq[i], 8, 1'b1);
    end
    repeat (BIT) @(posedge pclk);
    rdchk("ovr", 8'h10, 32'h0c, 32'h0c);
    repeat (2) rdchk("rxd", 8'h0c, 32'h3ff, {23'h0, rxq.pop_front()});
    rdchk("rx_empty", 8'h10, 32'h04, 32'h0);
    wr(8'h10, 32'h8);
    rdchk("w1c", 8'h10, 32'h08, 32'h0);
    v = {23'h0, 9'($urandom) & 9'h0ff};
    u_rem.send(v[8:0], 8, 1'b0);
    repeat (BIT) @(posedge pclk);
    rdchk("ferr", 8'h10, 32'h84, 32'h84);
    rdchk("rxf", 8'h0c, 32'h3ff, {22'h0, 1'b1, v[8:0]});
    // Address mode keeps only characters with the ninth bit set
    wr(8'h00, 32'h5d);
    u_rem.send(9'h0a5, 9, 1'b1);
    u_rem.send(9'h1c3, 9, 1'b1);
    repeat (BIT) @(posedge pclk);
    rdchk("addr", 8'h0c, 32'h3ff, 32'h1c3);
    rdchk("addr_one", 8'h10, 32'h04, 32'h0);
    wr(8'h00, 32'h145);
    u_rem.send(9'h000, 8, 1'b1);
    rdchk("wake", 8'h10, 32'h40, 32'h40);
    rdchk("wake_clr", 8'h00, 32'h100, 32'h0);
    // Autobaud last: the receiver wakes up in mid character
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h245);
    u_rem.send(9'h055, 8, 1'b1);
    rdchk("abd", 8'h04, 32'hffff, 32'h1);
    rdchk("abd_clr", 8'h00, 32'h200, 32'h0);
    print_verdict();
  end
endmodule // tb_async_serial_framing_core
`default_nettype wire
